// ===== bench/ihcp_dev_model.sv
// Behavioural model of the decoder's serial control port, slave side
module ihcp_dev_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Link pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o,
    output logic attn_n_o,
    // Received byte strobe
    output logic rx_stb_o,
    output logic [7:0] rx_byte_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_q[$]; // Outgoing bytes, filled by the bench
    int nack_addr = 0; // Read address bytes still to refuse
    int nack_data = 0; // Write data bytes still to refuse
    logic scl_d, sda_d, act, rd, first, ok;
    int bitc; // Rising clock edges since byte start
    logic [7:0] sh; // Incoming shift register
    logic [7:0] tx; // Byte being sent
    // Pins sampled on the fast clock, so edges are seen one cycle late
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {scl_d, sda_d, act, rd, first, sda_oe_o, attn_n_o, rx_stb_o} <= 8'hC2;
            bitc <= 0;
        end else begin
            scl_d <= scl_i;
            sda_d <= sda_i;
            rx_stb_o <= 1'b0;
            // Attention only falls between transfers
            if (tx_q.size() > 0 && !act) attn_n_o <= 1'b0;
            if (scl_i && scl_d && sda_d && !sda_i) begin
                {act, rd, first, sda_oe_o} <= 4'hA;
                bitc <= 0;
            end else if (scl_i && scl_d && !sda_d && sda_i) begin
                act <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (act && scl_i && !scl_d) begin
                // Rising edge: take a bit, watch the host's ack
                if (bitc < 8) sh <= {sh[6:0], sda_i};
                if (bitc == 8 && rd && !first && sda_i) act <= 1'b0;
                if (bitc == 7 && rd && !first && tx_q.size() == 0) attn_n_o <= 1'b1;
                bitc <= bitc + 1;
            end else if (act && !scl_i && scl_d) begin
                if (bitc == 8 && !(rd && !first)) begin
                    // Ack slot of a received byte
                    ok = first ? (sh[7:1] == 7'h00 && !(sh[0] && nack_addr > 0)) : nack_data == 0;
                    if (first && sh[0] && nack_addr > 0) nack_addr--;
                    if (!first && nack_data > 0) nack_data--;
                    sda_oe_o <= ok;
                    if (ok && first) rd <= sh[0];
                    rx_stb_o <= ok && !(first && sh[0]);
                    rx_byte_o <= sh;
                end else if (bitc == 9) begin
                    // Next byte, first read bit out
                    bitc <= 0;
                    first <= 1'b0;
                    tx = (rd && tx_q.size() > 0) ? tx_q.pop_front() : 8'hFF;
                    sda_oe_o <= rd && !tx[7];
                end else if (bitc == 8) begin
                    sda_oe_o <= 1'b0; // Host owns the ack slot
                end else if (rd && !first) begin
                    sda_oe_o <= !tx[7 - bitc];
                end
            end
        end
    end
endmodule : ihcp_dev_model

// ===== bench/ihcp_master_props.sv
// Checker of the master's link pin and status behaviour
module ihcp_master_props #(
    parameter int HALF_CYC = 8,
    parameter int RST_CYC = 4
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Watched outputs
    input wire ihcp_pkg::ihcp_rd_data_t rd_data_o,
    input wire logic busy_o,
    input wire logic wr_fail_o,
    input wire logic serial_ctrl_clock_o,
    input wire logic serial_ctrl_data_io_oe_o,
    input wire logic device_reset_n_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire logic scl = serial_ctrl_clock_o;
    wire logic oe = serial_ctrl_data_io_oe_o;
    int rst_cnt; // Low cycles of the device reset pulse
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) rst_cnt <= 0;
        else rst_cnt <= device_reset_n_o ? 0 : rst_cnt + 1;
    end
    // Start: data pulled with clock high, clock falls a quarter later
    sequence s_start; $rose(oe) && scl; endsequence
    sequence s_fall; scl[*3] ##[1:6] !scl; endsequence
    property p_start; s_start |-> s_fall; endproperty
    a_start: assert property (p_start) else $error("start without clock fall");
    property p_stop; $fell(oe) && scl && $past(scl) |-> scl[*4]; endproperty
    a_stop: assert property (p_stop) else $error("clock moved after stop");
    property p_stable; $rose(scl) |-> $stable(oe); endproperty
    a_stable: assert property (p_stable) else $error("data moved at clock rise");
    property p_idle; $fell(busy_o) |-> scl && !oe; endproperty
    a_idle: assert property (p_idle) else $error("bus not idle at end");
    property p_ack; rd_data_o.valid && !rd_data_o.last |-> ##[1:8] oe; endproperty
    a_ack: assert property (p_ack) else $error("no ack before more data");
    property p_nack; rd_data_o.valid && rd_data_o.last |-> !oe[*8]; endproperty
    a_nack: assert property (p_nack) else $error("final byte acknowledged");
    property p_rst_idle; $fell(device_reset_n_o) |-> scl && !oe; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("reset before stop");
    property p_rst_w; $rose(device_reset_n_o) |-> rst_cnt == RST_CYC; endproperty
    a_rst_w: assert property (p_rst_w) else $error("device reset width wrong");
    property p_fail; wr_fail_o |=> !wr_fail_o; endproperty
    a_fail: assert property (p_fail) else $error("write fail not a pulse");
endmodule : ihcp_master_props
bind ihcp_master ihcp_master_props #(.HALF_CYC(HALF_CYC), .RST_CYC(RST_CYC)) i_ihcp_master_props (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .rd_data_o(rd_data_o),
    .busy_o(busy_o),
    .wr_fail_o(wr_fail_o),
    .serial_ctrl_clock_o(serial_ctrl_clock_o),
    .serial_ctrl_data_io_oe_o(serial_ctrl_data_io_oe_o),
    .device_reset_n_o(device_reset_n_o)
);

// ===== bench/ihcp_master_test.sv
// Self-checking bench of the host control port master
module ihcp_master_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Clock, wiring and notes
    // ==========================================================
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    ihcp_pkg::ihcp_wr_cmd_t wr_cmd = '0;
    ihcp_pkg::ihcp_rd_data_t rd_data;
    logic wr_ready, busy, wr_fail, scl, m_o, m_oe, attn_n, dev_rst_n, d_oe, rx_stb;
    logic fail_seen, rst_seen; // Flags seen during one write
    logic [7:0] rx_byte;
    wire logic sda = !((m_oe && !m_o) || d_oe); // Open drain with pull-up
    logic [7:0] exp_wr[$]; // Bytes the device should receive
    logic [8:0] exp_rd[$]; // {last, data} the master should deliver
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    always #2.5 clk = !clk;
    ihcp_master #(.HALF_CYC(8), .RST_CYC(4)) i_ihcp_master (.clock_i(clk), .rst_n_i(rst_n),
        .clk_en_i(1'b1), .wr_cmd_i(wr_cmd), .wr_ready_o(wr_ready), .rd_data_o(rd_data),
        .busy_o(busy), .wr_fail_o(wr_fail), .serial_ctrl_clock_o(scl),
        .serial_ctrl_data_io_i(sda), .serial_ctrl_data_io_o(m_o),
        .serial_ctrl_data_io_oe_o(m_oe), .host_attention_n_i(attn_n),
        .device_reset_n_o(dev_rst_n));
    ihcp_dev_model i_ihcp_dev_model (.clock_i(clk), .rst_n_i(rst_n & dev_rst_n), .scl_i(scl),
        .sda_i(sda), .sda_oe_o(d_oe), .attn_n_o(attn_n), .rx_stb_o(rx_stb), .rx_byte_o(rx_byte));
    // ==========================================================
    // Compare, verdict and watchdog
    // ==========================================================
    task automatic cmp_byte(input string what, input logic [8:0] e, input logic [8:0] s);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask : cmp_byte
    task automatic cmp_flag(input string what, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %b seen %b", what, e, s);
        end
    endtask : cmp_flag
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    // Watchdog well above test length
    always @(posedge clk) begin
        if (++cyc == 30000) begin
            error_cnt++;
            give_verdict();
        end
    end
    // Watcher: oldest note against each result as it appears
    always @(posedge clk) begin
        if (wr_fail === 1'b1) fail_seen <= 1'b1;
        if (dev_rst_n === 1'b0) rst_seen <= 1'b1;
        if (rx_stb) cmp_byte("rx byte", {1'b0, exp_wr.pop_front()}, {1'b0, rx_byte});
        if (rd_data.valid) cmp_byte("rd byte", exp_rd.pop_front(), {rd_data.last, rd_data.data});
    end
    // ==========================================================
    // Drivers
    // ==========================================================
    task automatic do_write(input int n, input int nack);
        logic [7:0] b;
        int t;
        {fail_seen, rst_seen} = 2'b00;
        exp_wr.push_back(ihcp_pkg::ADDR_WRITE);
        i_ihcp_dev_model.nack_data = nack;
        for (int k = 0; k < n; k++) begin
            b = 8'($urandom());
            if (nack < 2) exp_wr.push_back(b);
            @(negedge clk);
            wr_cmd = '{valid: 1'b1, last: (k == n - 1), data: b};
            t = 0;
            do @(negedge clk); while (wr_ready !== 1'b1 && ++t < 3000);
            wr_cmd = '0;
        end
        t = 0;
        do @(negedge clk); while ((busy !== 1'b0 || dev_rst_n !== 1'b1) && ++t < 3000);
        cmp_flag("wr_fail", nack > 1, fail_seen);
        cmp_flag("device reset", nack > 1, rst_seen);
        cmp_flag("rx pending", 1'b0, exp_wr.size() != 0);
        $display("test write %0d bytes with %0d refusals done", n, nack);
    endtask : do_write
    task automatic do_read(input int n, input int nack);
        logic [7:0] b;
        int t;
        i_ihcp_dev_model.nack_addr = nack;
        for (int k = 0; k < n; k++) begin
            b = 8'($urandom());
            exp_rd.push_back({k == n - 1, b});
            i_ihcp_dev_model.tx_q.push_back(b);
        end
        t = 0;
        do @(negedge clk); while ((exp_rd.size() != 0 || busy !== 1'b0) && ++t < 5000);
        cmp_flag("rd pending", 1'b0, exp_rd.size() != 0);
        $display("test read %0d bytes with %0d refusals done", n, nack);
    endtask : do_read
    // Main sequence
    initial begin
        void'($urandom(32'h480C));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        do_write(1, 0);
        do_write(4, 0);
        do_write(2, 1);
        do_write(1, 2);
        do_read(1, 0);
        do_read(3, 0);
        do_read(2, 1);
        do_write(2, 0);
        give_verdict();
    end
endmodule : ihcp_master_test

// ===== pkg/ihcp_pkg.sv
// Package with constants and carrier types for the I2C host control port master
package ihcp_pkg;
    // =========================================================
    // Bus addressing
    // =========================================================
    localparam logic [7:0] ADDR_WRITE = 8'h00;   // Device address 0000000b, write bit 0
    localparam logic [7:0] ADDR_READ = 8'h01;    // Device address 0000000b, read bit 1
    localparam logic [3:0] BITS_PER_BYTE = 4'h8; // Data bits before the acknowledge slot
    localparam logic [2:0] MSB_INDEX = 3'h7;     // First bit shifted out
    localparam int WRITE_TRIES = 2;              // Original send plus one resend

    // =========================================================
    // Timing
    // =========================================================
    localparam int CLK_HZ = 200_000_000;         // System clock rate
    localparam int SCL_HALF_NS = 1250;           // Half period of the serial clock
    localparam int SCL_HALF_CYC = (SCL_HALF_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int RESET_PULSE_NS = 1000;        // Device reset pulse width
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;

    // =========================================================
    // Carrier types
    // =========================================================
    typedef struct packed {
        logic valid;   // Command present
        logic last;    // Last byte of this write transfer
        logic [7:0] data; // Byte to write
    } ihcp_wr_cmd_t;

    typedef struct packed {
        logic valid;   // One-cycle strobe for a received byte
        logic last;    // Final byte of the read sequence
        logic [7:0] data; // Byte read from the device
    } ihcp_rd_data_t;

    typedef struct packed {
        logic scl_o;   // Serial clock output level
        logic sda_o;   // Data output level (always low when enabled)
        logic sda_oe;  // Data output enable, high while driving
    } ihcp_pins_t;
endpackage : ihcp_pkg

// ===== rtl/ihcp_master.sv
// I2C host-side master for the serial control port of an audio decoder DSP
// Function
// - Host generates start: data falls, clock high
// - Write begins with address byte 0x00
// - Host releases data, gives ninth clock
// - No ack: resend once, then stop, reset
// - Bytes shifted most significant bit first
// - Host ends transfers with stop condition
// - Attention low: start, then address 0x01
// - Read address refused: stop, restart read
// - Attention still low: acknowledge, read more
// - Attention risen: no-acknowledge then stop
// - Host reads all pending data in one cycle
// - Attention falls after stop: new read
// - Protocol independent of transfer length
module ihcp_master #(
    parameter int HALF_CYC = ihcp_pkg::SCL_HALF_CYC,   // System cycles per half serial clock
    parameter int RST_CYC = ihcp_pkg::RESET_PULSE_CYC  // System cycles of device reset
) (
    // Clock, reset and enable
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Write command stream
    input wire ihcp_pkg::ihcp_wr_cmd_t wr_cmd_i,
    output logic wr_ready_o,
    // Read data stream
    output ihcp_pkg::ihcp_rd_data_t rd_data_o,
    // Status
    output logic busy_o,
    output logic wr_fail_o,
    // Link pins
    output logic serial_ctrl_clock_o,
    input wire logic serial_ctrl_data_io_i,
    output logic serial_ctrl_data_io_o,
    output logic serial_ctrl_data_io_oe_o,
    input wire logic host_attention_n_i,
    output logic device_reset_n_o
);
    // =========================================================
    // Elaboration checks
    // =========================================================
    if (HALF_CYC < 2 || RST_CYC < 1) begin : g_bad_param
        $error("HALF_CYC below 2 or RST_CYC below 1");
    end

    // Master states
    typedef enum logic [3:0] {
        ST_IDLE, ST_START, ST_SEND, ST_ACK_IN, ST_RECV, ST_ACK_OUT,
        ST_STOP_A, ST_STOP_B, ST_DEV_RESET
    } ihcp_state_t;

    // Quarter phases of one serial bit: low-set, rise, high-sample, fall
    typedef enum logic [1:0] {PH_LOW, PH_RISE, PH_HIGH, PH_FALL} ihcp_phase_t;

    // =========================================================
    // Input synchronisers
    // =========================================================
    logic sda_meta;  // First stage, read only by sda_sync
    logic sda_sync;  // Settled data level
    logic att_meta;  // First stage, read only by att_sync
    logic att_sync;  // Settled attention level, low means data pending

    // Two flops each, so no logic sees a half-settled level
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            att_meta <= 1'b1;
            att_sync <= 1'b1;
        end else if (clk_en_i) begin
            sda_meta <= serial_ctrl_data_io_i;
            sda_sync <= sda_meta;
            att_meta <= host_attention_n_i;
            att_sync <= att_meta;
        end
    end

    // =========================================================
    // Quarter-bit timebase
    // =========================================================
    localparam int TW = $clog2(HALF_CYC + RST_CYC + 1);
    logic [TW-1:0] tick_cnt;   // Counts down one quarter bit
    logic tick;                // One cycle at each quarter boundary
    ihcp_phase_t phase;        // Current quarter of the bit

    // Truncating cast of an integer to the counter width
    function automatic logic [TW-1:0] to_tw(input int v);
        return TW'(v);
    endfunction : to_tw

    assign tick = (tick_cnt == '0);

    // Free-running quarter-bit reload
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_cnt <= '0;
        end else if (clk_en_i) begin
            if (tick) begin
                tick_cnt <= to_tw(HALF_CYC / 2 - 1);
            end else begin
                tick_cnt <= tick_cnt - 1'b1;
            end
        end
    end

    // =========================================================
    // Main sequencer
    // =========================================================
    ihcp_state_t state;     // Sequencer state
    logic [7:0] shreg;      // Byte being shifted
    logic [3:0] bit_cnt;    // Bits shifted in this byte
    logic reading;          // Current transaction is a read
    logic addr_phase;       // Current byte is the address
    logic try_again;        // Resend already used for this byte
    logic after_fail;       // Stop must be followed by a device reset
    logic nack_seen;        // Last acknowledge slot saw a high line
    logic last_rd;          // Attention was high at the final data bit
    logic wr_last;          // Held last flag of the current write byte
    logic [7:0] wr_hold;    // Held copy of current write byte for resend
    logic [TW-1:0] rst_cnt; // Device reset pulse counter

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            phase <= PH_LOW;
            shreg <= 8'h00;
            bit_cnt <= 4'h0;
            reading <= 1'b0;
            addr_phase <= 1'b0;
            try_again <= 1'b0;
            after_fail <= 1'b0;
            nack_seen <= 1'b0;
            last_rd <= 1'b0;
            wr_last <= 1'b0;
            wr_hold <= 8'h00;
            rst_cnt <= '0;
            serial_ctrl_clock_o <= 1'b1;
            serial_ctrl_data_io_o <= 1'b0;
            serial_ctrl_data_io_oe_o <= 1'b0;
            wr_ready_o <= 1'b0;
            rd_data_o <= '0;
            busy_o <= 1'b0;
            wr_fail_o <= 1'b0;
            device_reset_n_o <= 1'b1;
        end else if (clk_en_i) begin
            rd_data_o.valid <= 1'b0;
            wr_ready_o <= 1'b0;
            wr_fail_o <= 1'b0;
            case (state)
                // Read has priority; a pending write waits for the next stop
                ST_IDLE: begin
                    serial_ctrl_clock_o <= 1'b1;
                    serial_ctrl_data_io_oe_o <= 1'b0;
                    busy_o <= 1'b0;
                    if (tick && (!att_sync || wr_cmd_i.valid)) begin
                        reading <= !att_sync;
                        shreg <= !att_sync ? ihcp_pkg::ADDR_READ
                                           : ihcp_pkg::ADDR_WRITE;
                        wr_hold <= ihcp_pkg::ADDR_WRITE; // Reads never resend
                        addr_phase <= 1'b1;
                        try_again <= 1'b0;
                        busy_o <= 1'b1;
                        state <= ST_START;
                    end
                end
                // Data falls while clock high, then clock falls
                ST_START: begin
                    if (tick) begin
                        if (phase == PH_LOW) begin
                            serial_ctrl_data_io_oe_o <= 1'b1;
                            phase <= PH_RISE;
                        end else begin
                            serial_ctrl_clock_o <= 1'b0;
                            phase <= PH_LOW;
                            state <= ST_SEND;
                        end
                    end
                end
                // Shift out one byte, data changes only while clock low
                ST_SEND: begin
                    if (tick) begin
                        case (phase)
                            PH_LOW: begin
                                serial_ctrl_data_io_oe_o <= !shreg[ihcp_pkg::MSB_INDEX];
                                phase <= PH_RISE;
                            end
                            PH_RISE: begin
                                serial_ctrl_clock_o <= 1'b1;
                                phase <= PH_HIGH;
                            end
                            PH_HIGH: begin
                                phase <= PH_FALL;
                            end
                            default: begin
                                serial_ctrl_clock_o <= 1'b0;
                                shreg <= {shreg[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 1'b1;
                                phase <= PH_LOW;
                                if (bit_cnt == ihcp_pkg::BITS_PER_BYTE - 1'b1) begin
                                    state <= ST_ACK_IN;
                                end
                            end
                        endcase
                    end
                end
                // Release data and give the ninth clock for the acknowledge
                ST_ACK_IN: begin
                    if (tick) begin
                        case (phase)
                            PH_LOW: begin
                                serial_ctrl_data_io_oe_o <= 1'b0;
                                phase <= PH_RISE;
                            end
                            PH_RISE: begin
                                serial_ctrl_clock_o <= 1'b1;
                                phase <= PH_HIGH;
                            end
                            PH_HIGH: begin
                                nack_seen <= sda_sync;
                                phase <= PH_FALL;
                            end
                            default: begin
                                serial_ctrl_clock_o <= 1'b0;
                                phase <= PH_LOW;
                                bit_cnt <= 4'h0;
                                if (nack_seen && reading) begin
                                    state <= ST_STOP_A;
                                end else if (nack_seen && !try_again) begin
                                    try_again <= 1'b1;
                                    shreg <= wr_hold;
                                    state <= ST_SEND;
                                end else if (nack_seen) begin
                                    after_fail <= 1'b1;
                                    state <= ST_STOP_A;
                                end else if (reading) begin
                                    addr_phase <= 1'b0;
                                    state <= ST_RECV;
                                end else if (!addr_phase && wr_last) begin
                                    state <= ST_STOP_A;
                                end else if (wr_cmd_i.valid) begin
                                    // Next byte taken, whatever the transfer length
                                    shreg <= wr_cmd_i.data;
                                    wr_hold <= wr_cmd_i.data;
                                    wr_last <= wr_cmd_i.last;
                                    wr_ready_o <= 1'b1;
                                    addr_phase <= 1'b0;
                                    try_again <= 1'b0;
                                    state <= ST_SEND;
                                end else begin
                                    // Source ran dry: close the transfer cleanly
                                    state <= ST_STOP_A;
                                end
                            end
                        endcase
                    end
                end
                // Sample each bit while the clock is high
                ST_RECV: begin
                    if (tick) begin
                        case (phase)
                            PH_LOW: begin
                                serial_ctrl_data_io_oe_o <= 1'b0;
                                phase <= PH_RISE;
                            end
                            PH_RISE: begin
                                serial_ctrl_clock_o <= 1'b1;
                                phase <= PH_HIGH;
                            end
                            PH_HIGH: begin
                                shreg <= {shreg[6:0], sda_sync};
                                // Attention read after the last bit's rising edge
                                last_rd <= att_sync;
                                phase <= PH_FALL;
                            end
                            default: begin
                                serial_ctrl_clock_o <= 1'b0;
                                bit_cnt <= bit_cnt + 1'b1;
                                phase <= PH_LOW;
                                if (bit_cnt == ihcp_pkg::BITS_PER_BYTE - 1'b1) begin
                                    rd_data_o.valid <= 1'b1;
                                    rd_data_o.data <= shreg;
                                    rd_data_o.last <= last_rd;
                                    state <= ST_ACK_OUT;
                                end
                            end
                        endcase
                    end
                end
                // Acknowledge while attention low, no-acknowledge once it rose
                ST_ACK_OUT: begin
                    if (tick) begin
                        case (phase)
                            PH_LOW: begin
                                serial_ctrl_data_io_oe_o <= !last_rd;
                                phase <= PH_RISE;
                            end
                            PH_RISE: begin
                                serial_ctrl_clock_o <= 1'b1;
                                phase <= PH_HIGH;
                            end
                            PH_HIGH: begin
                                phase <= PH_FALL;
                            end
                            default: begin
                                serial_ctrl_clock_o <= 1'b0;
                                bit_cnt <= 4'h0;
                                phase <= PH_LOW;
                                state <= last_rd ? ST_STOP_A : ST_RECV;
                            end
                        endcase
                    end
                end
                // Pull data low with clock low, then raise clock
                ST_STOP_A: begin
                    if (tick) begin
                        if (phase == PH_LOW) begin
                            serial_ctrl_data_io_oe_o <= 1'b1;
                            phase <= PH_RISE;
                        end else begin
                            serial_ctrl_clock_o <= 1'b1;
                            phase <= PH_LOW;
                            state <= ST_STOP_B;
                        end
                    end
                end
                // Data rises while clock high to mark the stop
                ST_STOP_B: begin
                    if (tick) begin
                        serial_ctrl_data_io_oe_o <= 1'b0;
                        if (after_fail) begin
                            device_reset_n_o <= 1'b0;
                            wr_fail_o <= 1'b1;
                            rst_cnt <= to_tw(RST_CYC - 1);
                            state <= ST_DEV_RESET;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                // Hold the device in reset, drop the failed transfer
                ST_DEV_RESET: begin
                    if (rst_cnt == '0) begin
                        device_reset_n_o <= 1'b1;
                        after_fail <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        rst_cnt <= rst_cnt - 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : ihcp_master
